/* sim_map.vh */
// register map and timing constants of the system integrity monitor
`ifndef SIM_MAP_VH
`define SIM_MAP_VH

`define SIM_CSR_OFFSET      12'h000
`define SIM_CSR_RESET       8'h00

`define SIM_BIT_SRC_SEL     7
`define SIM_BIT_AVD_IE      6
`define SIM_BIT_AVD_FLAG    5
`define SIM_BIT_LVD_CAUSE   4
`define SIM_BIT_RESERVED    3
`define SIM_BIT_CSS_IE      2
`define SIM_BIT_CSS_DET     1
`define SIM_BIT_WDG_CAUSE   0

`define SIM_LOSS_CYCLES     8
`define SIM_FILTER_CYCLES   2

`endif

/* clock_loss_watch.v */
// main oscillator activity watch with optional spike filter
module clock_loss_watch #(
  parameter LOSS_CYCLES   = 8,
  parameter FILTER_CYCLES = 2,
  parameter CNT_W         = 8
) (
  input  wire clk,
  input  wire rst,
  input  wire enable,
  input  wire filter_on,
  input  wire osc_in,
  output wire lost
);

  localparam [CNT_W-1:0] LOSS_MAX   = LOSS_CYCLES;
  localparam [CNT_W-1:0] FILTER_MAX = FILTER_CYCLES;
  localparam [CNT_W-1:0] CNT_ONE    = 1;

  reg             osc_meta_q;
  reg             osc_sync_q;
  reg             osc_prev_q;
  reg             level_q;
  reg [CNT_W-1:0] stable_q;
  reg [CNT_W-1:0] idle_q;
  reg             lost_q;

  wire sample_changed = osc_sync_q != osc_prev_q;
  wire level_move     = (osc_prev_q != level_q) &&
                        (!filter_on || stable_q >= FILTER_MAX);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      osc_meta_q <= 1'b0;
      osc_sync_q <= 1'b0;
    end else begin
      osc_meta_q <= osc_in;
      osc_sync_q <= osc_meta_q;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      osc_prev_q <= 1'b0;
      stable_q   <= {CNT_W{1'b0}};
      level_q    <= 1'b0;
      idle_q     <= {CNT_W{1'b0}};
      lost_q     <= 1'b0;
    end else if (!enable) begin
      osc_prev_q <= osc_sync_q;
      stable_q   <= {CNT_W{1'b0}};
      level_q    <= osc_sync_q;
      idle_q     <= {CNT_W{1'b0}};
      lost_q     <= 1'b0;
    end else begin
      osc_prev_q <= osc_sync_q;
      // with filter_on set, spikes shorter than the filter span never move the level
      if (sample_changed) begin
        stable_q <= CNT_ONE;
      end else if (stable_q < FILTER_MAX) begin
        stable_q <= stable_q + CNT_ONE;
      end
      if (level_move) begin
        level_q <= osc_prev_q;
        idle_q  <= {CNT_W{1'b0}};
        lost_q  <= 1'b0;
      end else if (idle_q >= LOSS_MAX) begin
        lost_q <= 1'b1;
      end else begin
        idle_q <= idle_q + CNT_ONE;
      end
    end
  end

  assign lost = lost_q;

endmodule

/* system_integrity_monitor.v */
// system integrity monitor: voltage detector, clock watch and control/status register
`include "sim_map.vh"

module system_integrity_monitor #(
  parameter ADDR_W        = 12,
  parameter LOSS_CYCLES   = `SIM_LOSS_CYCLES,
  parameter FILTER_CYCLES = `SIM_FILTER_CYCLES
) (
  input  wire              CLK,
  input  wire              RESET,
  input  wire              HSEL,
  input  wire [ADDR_W-1:0] HADDR,
  input  wire [1:0]        HTRANS,
  input  wire              HWRITE,
  input  wire [2:0]        HSIZE,
  input  wire [31:0]       HWDATA,
  input  wire              HREADY,
  output wire              HREADYOUT,
  output wire              HRESP,
  output wire [31:0]       HRDATA,
  input  wire              LVD_OPTION_EN,
  input  wire              CSS_OPTION_EN,
  input  wire              PLL_ENABLE,
  input  wire              SUPPLY_CMP,
  input  wire              SENSE_CMP,
  input  wire              MAIN_OSC,
  input  wire              LVD_RESET_CAUSE,
  input  wire              WDG_RESET_CAUSE,
  input  wire              GLOBAL_MASK,
  input  wire              WAIT_MODE,
  input  wire              HALT_MODE,
  input  wire              AVD_IRQ_ACK,
  output wire              AVD_IRQ,
  output wire              CSS_IRQ,
  output wire              WAIT_WAKE,
  output wire              SAFE_CLK_SEL,
  output wire              SAFE_OSC_EN
);

  ////////////////////////////////////////////////////////////////////////////////
  // constants

  localparam [ADDR_W-1:0] CSR_ADDR  = `SIM_CSR_OFFSET;
  localparam [7:0]        CSR_RESET = `SIM_CSR_RESET;

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  reg  [1:0] cmp_meta_q;
  reg  [1:0] cmp_sync_q;

  reg        src_sel_q;
  reg        avd_ie_q;
  reg        avd_flag_q;
  reg        lvd_cause_q;
  reg        css_ie_q;
  reg        css_det_q;
  reg        wdg_cause_q;
  reg        avd_pend_q;
  reg        armed_q;
  reg        caught_q;
  reg        safe_sel_q;

  reg        src_sel_d;
  reg        avd_ie_d;
  reg        avd_flag_d;
  reg        lvd_cause_d;
  reg        css_ie_d;
  reg        css_det_d;
  reg        wdg_cause_d;
  reg        avd_pend_d;

  reg        wr_active_q;
  reg        rd_active_q;
  reg        hit_q;

  wire       accept;
  wire       addr_hit;
  wire       wr_done;
  wire       rd_done;
  wire [7:0] wdata;
  wire [7:0] csr_value;
  wire       avd_live;
  wire       avd_toggle;
  wire       avd_enable_rise;
  wire       avd_set;
  wire       avd_clr;
  wire       css_watch_on;
  wire       main_lost;
  wire       css_req;
  wire       frozen;

  ////////////////////////////////////////////////////////////////////////////////
  // comparator input synchronisers

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      cmp_meta_q <= 2'h0;
      cmp_sync_q <= 2'h0;
    end else begin
      cmp_meta_q <= {SENSE_CMP, SUPPLY_CMP};
      cmp_sync_q <= cmp_meta_q;
    end
  end

  assign avd_live = src_sel_q ? cmp_sync_q[1] : cmp_sync_q[0];

  ////////////////////////////////////////////////////////////////////////////////
  // bus slave

  // zero wait state, always OKAY; HSIZE is ignored and any access size to the word hits
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;

  assign accept   = HSEL && HREADY && HTRANS[1];
  assign addr_hit = {HADDR[ADDR_W-1:2], 2'b00} == CSR_ADDR;

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      wr_active_q <= 1'b0;
      rd_active_q <= 1'b0;
      hit_q       <= 1'b0;
    end else if (HREADY) begin
      wr_active_q <= accept && HWRITE;
      rd_active_q <= accept && !HWRITE;
      hit_q       <= accept && addr_hit;
    end
  end

  assign frozen  = HALT_MODE;
  assign wr_done = wr_active_q && hit_q && HREADY && !frozen;
  assign rd_done = rd_active_q && hit_q && HREADY && !frozen;
  assign wdata   = HWDATA[7:0];

  assign HRDATA = (rd_active_q && hit_q) ? {24'h000000, csr_value} : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////////
  // clock watch

  // watch and safe oscillator off in halt
  assign css_watch_on = CSS_OPTION_EN && !HALT_MODE;

  clock_loss_watch #(
    .LOSS_CYCLES   (LOSS_CYCLES),
    .FILTER_CYCLES (FILTER_CYCLES),
    .CNT_W         (8)
  ) u_watch (
    .clk       (CLK),
    .rst       (RESET),
    .enable    (css_watch_on),
    .filter_on (PLL_ENABLE),
    .osc_in    (MAIN_OSC),
    .lost      (main_lost)
  );

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      safe_sel_q <= 1'b0;
    end else begin
      safe_sel_q <= main_lost && css_watch_on;
    end
  end

  assign SAFE_CLK_SEL = safe_sel_q;
  assign SAFE_OSC_EN  = css_watch_on;

  ////////////////////////////////////////////////////////////////////////////////
  // voltage detector events

  // no edge on the first cycle after reset
  assign avd_toggle      = armed_q && (avd_flag_d != avd_flag_q);
  assign avd_enable_rise = wr_done && wdata[`SIM_BIT_AVD_IE] && !avd_ie_q;

  // both edges in supply and sense pin mode
  assign avd_set = (avd_toggle && avd_ie_q) || (avd_enable_rise && avd_flag_q);

  assign avd_clr = AVD_IRQ_ACK || (wr_done && !wdata[`SIM_BIT_AVD_IE]);

  ////////////////////////////////////////////////////////////////////////////////
  // register next values

  always @* begin
    src_sel_d   = src_sel_q;
    avd_ie_d    = avd_ie_q;
    avd_flag_d  = avd_flag_q;
    lvd_cause_d = lvd_cause_q;
    css_ie_d    = css_ie_q;
    css_det_d   = css_det_q;
    wdg_cause_d = wdg_cause_q;
    avd_pend_d  = avd_pend_q;
    if (!frozen) begin
      avd_flag_d = LVD_OPTION_EN ? avd_live : 1'b0;
      if (wr_done) begin
        src_sel_d = wdata[`SIM_BIT_SRC_SEL];
        avd_ie_d  = wdata[`SIM_BIT_AVD_IE];
        css_ie_d  = wdata[`SIM_BIT_CSS_IE];
        if (!wdata[`SIM_BIT_LVD_CAUSE]) begin
          lvd_cause_d = 1'b0;
        end
        if (!wdata[`SIM_BIT_WDG_CAUSE]) begin
          wdg_cause_d = 1'b0;
        end
      end
      // read clears after recovery, set wins
      if (rd_done && !main_lost) begin
        css_det_d = 1'b0;
      end
      if (main_lost && css_watch_on) begin
        css_det_d = 1'b1;
      end
      if (!CSS_OPTION_EN) begin
        css_det_d = 1'b0;
      end
      if (avd_clr) begin
        avd_pend_d = 1'b0;
      end
      if (avd_set) begin
        avd_pend_d = 1'b1;
      end
    end else if (AVD_IRQ_ACK) begin
      avd_pend_d = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register flip-flops

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      src_sel_q  <= CSR_RESET[`SIM_BIT_SRC_SEL];
      avd_ie_q   <= CSR_RESET[`SIM_BIT_AVD_IE];
      avd_flag_q <= CSR_RESET[`SIM_BIT_AVD_FLAG];
      css_ie_q   <= CSR_RESET[`SIM_BIT_CSS_IE];
      css_det_q  <= CSR_RESET[`SIM_BIT_CSS_DET];
      avd_pend_q <= 1'b0;
      armed_q    <= 1'b0;
    end else begin
      src_sel_q  <= src_sel_d;
      avd_ie_q   <= avd_ie_d;
      avd_flag_q <= avd_flag_d;
      css_ie_q   <= css_ie_d;
      css_det_q  <= css_det_d;
      avd_pend_q <= avd_pend_d;
      armed_q    <= 1'b1;
    end
  end

  // reset-cause flags are caught on the first edge after release
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      lvd_cause_q <= CSR_RESET[`SIM_BIT_LVD_CAUSE];
      wdg_cause_q <= CSR_RESET[`SIM_BIT_WDG_CAUSE];
      caught_q    <= 1'b0;
    end else if (!caught_q) begin
      lvd_cause_q <= LVD_RESET_CAUSE;
      wdg_cause_q <= WDG_RESET_CAUSE && !LVD_RESET_CAUSE;
      caught_q    <= 1'b1;
    end else begin
      lvd_cause_q <= lvd_cause_d;
      wdg_cause_q <= wdg_cause_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read value and interrupt outputs

  // reserved bit reads as zero
  assign csr_value = {src_sel_q,
                      avd_ie_q,
                      avd_flag_q,
                      lvd_cause_q,
                      1'b0,
                      css_ie_q,
                      css_det_q,
                      wdg_cause_q};

  assign css_req = css_det_q && css_ie_q && CSS_OPTION_EN;

  assign AVD_IRQ = avd_pend_q && !GLOBAL_MASK;
  assign CSS_IRQ = css_req && !GLOBAL_MASK;

  assign WAIT_WAKE = WAIT_MODE && !HALT_MODE && (AVD_IRQ || CSS_IRQ);

endmodule

/* integrity_monitor.sv */
// assertion checker on the ports of the system integrity monitor
module integrity_checker #(
  parameter ADDR_W        = 12,
  parameter LOSS_CYCLES   = 8,
  parameter FILTER_CYCLES = 2
) (
  input wire              CLK,
  input wire              RESET,
  input wire              HSEL,
  input wire [ADDR_W-1:0] HADDR,
  input wire [1:0]        HTRANS,
  input wire              HWRITE,
  input wire              HREADY,
  input wire [31:0]       HRDATA,
  input wire              CSS_OPTION_EN,
  input wire              MAIN_OSC,
  input wire              GLOBAL_MASK,
  input wire              WAIT_MODE,
  input wire              HALT_MODE,
  input wire              AVD_IRQ,
  input wire              CSS_IRQ,
  input wire              WAIT_WAKE,
  input wire              SAFE_CLK_SEL,
  input wire              SAFE_OSC_EN
);
  timeunit 1ns;
  timeprecision 1ns;
  logic osc_q;
  int   quiet_q;
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  // cycles since the oscillator pin last moved while the watch runs
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      osc_q   <= 1'b0;
      quiet_q <= 0;
    end else begin
      osc_q   <= MAIN_OSC;
      quiet_q <= (MAIN_OSC != osc_q || !CSS_OPTION_EN || HALT_MODE) ? 0 : quiet_q + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence rd_hit;
    HSEL && HREADY && HTRANS[1] && !HWRITE && HADDR[ADDR_W-1:2] == 0;
  endsequence
  a_rsvd_reads: assert property (rd_hit |=> HRDATA[31:8] == 0 && !HRDATA[3])
    else $error("reserved bits read nonzero");
  a_css_off: assert property (rd_hit ##1 !CSS_OPTION_EN |-> !HRDATA[1])
    else $error("clock loss flag set with watch off");
  a_css_gate: assert property (CSS_IRQ |-> CSS_OPTION_EN && !GLOBAL_MASK)
    else $error("clock loss request not gated");
  a_avd_mask: assert property (GLOBAL_MASK |-> !AVD_IRQ)
    else $error("voltage request while masked");
  a_wake_gate: assert property (WAIT_WAKE == (WAIT_MODE && !HALT_MODE && (AVD_IRQ || CSS_IRQ)))
    else $error("wake output wrong");
  a_halt_osc: assert property (SAFE_OSC_EN == (CSS_OPTION_EN && !HALT_MODE))
    else $error("safe oscillator enable wrong");
  a_loss_sel: assert property (quiet_q >= LOSS_CYCLES + FILTER_CYCLES + 6 |-> SAFE_CLK_SEL)
    else $error("no switch to safe clock");
  a_osc_back: assert property ($changed(MAIN_OSC) && CSS_OPTION_EN && !HALT_MODE |-> ##[1:12] !SAFE_CLK_SEL)
    else $error("no return to main clock");
  a_sel_cause: assert property ($rose(SAFE_CLK_SEL) |-> CSS_OPTION_EN && quiet_q >= LOSS_CYCLES)
    else $error("safe clock chosen without loss");
endmodule

bind system_integrity_monitor integrity_checker #(
  .ADDR_W(ADDR_W), .LOSS_CYCLES(LOSS_CYCLES), .FILTER_CYCLES(FILTER_CYCLES)
) i_integrity_checker (
  .CLK(CLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HREADY(HREADY), .HRDATA(HRDATA), .CSS_OPTION_EN(CSS_OPTION_EN), .MAIN_OSC(MAIN_OSC),
  .GLOBAL_MASK(GLOBAL_MASK), .WAIT_MODE(WAIT_MODE), .HALT_MODE(HALT_MODE), .AVD_IRQ(AVD_IRQ),
  .CSS_IRQ(CSS_IRQ), .WAIT_WAKE(WAIT_WAKE), .SAFE_CLK_SEL(SAFE_CLK_SEL), .SAFE_OSC_EN(SAFE_OSC_EN)
);

/* integrity_far_side.sv */
// comparators and main oscillator facing the system integrity monitor
module integrity_far_side (
  input  wire  osc_run,
  input  wire  sup_low,
  input  wire  sen_low,
  output logic main_osc,
  output wire  supply_cmp,
  output wire  sense_cmp
);
  timeunit 1ns;
  timeprecision 1ns;
  initial main_osc = 1'b0;
  // free running oscillator unrelated to the cpu clock, frozen when broken
  always begin
    #350;
    if (osc_run)
      main_osc = !main_osc;
  end
  // comparator high means below threshold, changes off the clock edge
  assign #37 supply_cmp = sup_low;
  assign #37 sense_cmp  = sen_low;
endmodule

/* system_integrity_monitor_test.sv */
// self-checking testbench of the system integrity monitor
module system_integrity_monitor_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic        lvd_en = 1'b1, css_en = 1'b1, pll_en = 1'b1, lvd_c = 1'b0, wdg_c = 1'b0;
  logic        gmask = 1'b0, waitm = 1'b0, haltm = 1'b0, ack = 1'b0;
  logic        osc_run = 1'b1, sup = 1'b0, sen = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] hwdata = 32'h0, r;
  wire  [31:0] hrdata;
  wire         hreadyout, avd_irq, css_irq, wake, safe_sel, main_osc, sup_cmp, sen_cmp;
  wire         hresp;
  int          n_errors = 0, checked = 0;
  logic [15:0] rows [5] = '{16'hc4c4, 16'h4444, 16'h8080, 16'h0404, 16'h0000};

  system_integrity_monitor i_system_integrity_monitor (
    .CLK(clk), .RESET(reset), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRESP(hresp),
    .HRDATA(hrdata), .LVD_OPTION_EN(lvd_en), .CSS_OPTION_EN(css_en), .PLL_ENABLE(pll_en),
    .SUPPLY_CMP(sup_cmp), .SENSE_CMP(sen_cmp), .MAIN_OSC(main_osc), .LVD_RESET_CAUSE(lvd_c),
    .WDG_RESET_CAUSE(wdg_c), .GLOBAL_MASK(gmask), .WAIT_MODE(waitm), .HALT_MODE(haltm),
    .AVD_IRQ_ACK(ack), .AVD_IRQ(avd_irq), .CSS_IRQ(css_irq), .WAIT_WAKE(wake),
    .SAFE_CLK_SEL(safe_sel), .SAFE_OSC_EN()
  );
  integrity_far_side i_integrity_far_side (
    .osc_run(osc_run), .sup_low(sup), .sen_low(sen), .main_osc(main_osc),
    .supply_cmp(sup_cmp), .sense_cmp(sen_cmp)
  );

  always #50 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= a;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] d);
    bus(1'b1, 12'h000, d & 8'hf7);
  endtask
  task automatic rd(input logic [7:0] e);
    bus(1'b0, 12'h000, 8'h00);
    chk("csr", {24'h0, e}, r);
  endtask
  task automatic ackp;
    ack <= 1'b1;
    cyc(1);
    ack <= 1'b0;
    cyc(1);
  endtask
  task automatic rst(input logic l, input logic w);
    lvd_c <= l;
    wdg_c <= w;
    reset <= 1'b1;
    cyc(10);
    reset <= 1'b0;
    cyc(2);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #(100 * 3000);
    n_errors++;
    report_and_stop;
  end
  initial begin
    rst(1'b0, 1'b0);
    rd(8'h00);
    foreach (rows[i]) begin
      wr(rows[i][15:8]);
      rd(rows[i][7:0]);
      chk("avd_irq", 32'h0, avd_irq);
    end
    bus(1'b1, 12'h004, 8'hff);
    bus(1'b0, 12'h004, 8'h00);
    chk("unmapped", 32'h0, r);
    chk("hresp", 32'h0, hresp);
    rd(8'h00);
    $display("test registers done");
    rst(1'b1, 1'b1);
    rd(8'h10);
    wr(8'h00);
    rd(8'h00);
    rst(1'b0, 1'b1);
    rd(8'h01);
    wr(8'h00);
    rd(8'h00);
    $display("test reset causes done");
    sup <= 1'b1;
    cyc(6);
    rd(8'h20);
    chk("avd_irq", 32'h0, avd_irq);
    wr(8'h40);
    cyc(2);
    chk("avd_irq", 32'h1, avd_irq);
    ackp;
    chk("avd_irq", 32'h0, avd_irq);
    gmask <= 1'b1;
    sup   <= 1'b0;
    cyc(6);
    chk("avd_irq", 32'h0, avd_irq);
    gmask <= 1'b0;
    cyc(1);
    chk("avd_irq", 32'h1, avd_irq);
    waitm <= 1'b1;
    cyc(1);
    chk("wake", 32'h1, wake);
    haltm <= 1'b1;
    cyc(1);
    chk("wake", 32'h0, wake);
    wr(8'h00);
    rd(8'h40);
    haltm <= 1'b0;
    waitm <= 1'b0;
    wr(8'h00);
    cyc(1);
    chk("avd_irq", 32'h0, avd_irq);
    wr(8'hc0);
    sen <= 1'b1;
    cyc(6);
    chk("avd_irq", 32'h1, avd_irq);
    ackp;
    sen <= 1'b0;
    cyc(6);
    chk("avd_irq", 32'h1, avd_irq);
    ackp;
    wr(8'h80);
    lvd_en <= 1'b0;
    wr(8'hc0);
    sen <= 1'b1;
    cyc(6);
    chk("avd_irq", 32'h0, avd_irq);
    wr(8'h00);
    sen <= 1'b0;
    cyc(6);
    lvd_en <= 1'b1;
    cyc(6);
    $display("test voltage detector done");
    wr(8'h04);
    osc_run <= 1'b0;
    cyc(25);
    chk("safe_sel", 32'h1, safe_sel);
    chk("css_irq", 32'h1, css_irq);
    rd(8'h06);
    osc_run <= 1'b1;
    cyc(12);
    chk("safe_sel", 32'h0, safe_sel);
    rd(8'h06);
    rd(8'h04);
    chk("css_irq", 32'h0, css_irq);
    pll_en  <= 1'b0;
    css_en  <= 1'b0;
    osc_run <= 1'b0;
    cyc(25);
    rd(8'h04);
    chk("css_irq", 32'h0, css_irq);
    css_en  <= 1'b1;
    osc_run <= 1'b1;
    cyc(12);
    $display("test clock watch done");
    report_and_stop;
  end
endmodule
